// File: design/imlc_top.sv
// Summary of operation
// - Auto mode: reference pass, then monitor if wrap
// - Wait two to burden exponent plus one cycles between transfers
// - Branch disable forces next pointer to zero
// - End-monitor disable ignores descriptor end flag
// - Write-back disable forces no-write-back flag high
// - Auto compare digest overrides write-back disable
// - Bus error mask per region, bits 11:8
// - Mismatch mask per region, bits 7:4
// - Hash done mask per region, bits 3:0
`timescale 1ns/1ps
`default_nettype none
module imlc_top
  import imlc_pkg::*;
(
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // Avalon-MM slave.
  input  wire logic [4:0]            avsAddress,
  input  wire logic                  avsRead,
  input  wire logic                  avsWrite,
  input  wire logic [31:0]           avsWritedata,
  input  wire logic [3:0]            avsByteenable,
  output logic      [31:0]           avsReaddata,
  output logic                       avsWaitrequest,
  // Descriptor walker.
  output logic                       fetchReq,
  output logic                       restartList,
  input  wire logic                  descValid,
  input  wire logic [1:0]            descRegion,
  input  wire logic                  descWrap,
  input  wire logic                  descEndMon,
  input  wire logic                  descNoWb,
  input  wire logic                  descLast,
  input  wire logic [31:0]           descNext,
  // Block transfer engine.
  output logic                       xferReq,
  output logic [1:0]                 xferRegion,
  output logic [31:0]                xferNext,
  output logic                       xferNoWb,
  input  wire logic                  xferDone,
  // Region events, one-cycle pulses.
  input  wire logic [REGIONS-1:0]    evHashDone,
  input  wire logic [REGIONS-1:0]    evMismatch,
  input  wire logic [REGIONS-1:0]    evBusErr,
  // Status.
  output logic                       busy,
  output logic                       monitoring,
  output logic                       irq
);
  logic [CFG_W-1:0]  cfg_q, cfg_d;
  logic [MASK_W-1:0] mask_q, mask_d;
  logic [MASK_W-1:0] status_q, status_d;
  logic [31:0]       rdata_q, rdata_d;
  logic              wait_q, wait_d;
  logic              irq_q, irq_d;
  imlc_state_e       state_q, state_d;
  logic              refPass_q, refPass_d;
  logic              mon_q, mon_d;
  logic              restart_q, restart_d;
  logic              wrap_q, wrap_d;
  logic              endMon_q, endMon_d;
  logic              last_q, last_d;
  logic [1:0]        region_q, region_d;
  logic [31:0]       next_q, next_d;
  logic              noWb_q, noWb_d;
  logic              timerStart;
  logic              timerDone;
  logic              wrAcc;
  logic              rdAcc;
  logic [31:0]       wrMerged;
  logic [31:0]       oldWord;
  logic [MASK_W-1:0] events;
  logic              cmdStart;
  logic              cmdStop;
  logic              secondary_branch_disable;
  logic              endMonDis;
  logic              wbForce;
  logic              fetch_q, fetch_d, xfer_q, xfer_d, busy_q, busy_d;

  // A write is accepted on the cycle that waitrequest is low; a read is taken the cycle before, while it is high.
  assign wrAcc = avsWrite && !wait_q;
  assign rdAcc = avsRead && wait_q;
  assign oldWord = (avsAddress == OFF_CFG)  ? 32'(cfg_q)  :
                   (avsAddress == OFF_MASK) ? 32'(mask_q) : 32'h0000_0000;
  assign wrMerged = {avsByteenable[3] ? avsWritedata[31:24] : oldWord[31:24],
                     avsByteenable[2] ? avsWritedata[23:16] : oldWord[23:16],
                     avsByteenable[1] ? avsWritedata[15:8]  : oldWord[15:8],
                     avsByteenable[0] ? avsWritedata[7:0]   : oldWord[7:0]};
  assign cmdStart = wrAcc && avsAddress == OFF_CTRL && avsByteenable[0]
                    && avsWritedata[CTRL_START];
  assign cmdStop  = wrAcc && avsAddress == OFF_CTRL && avsByteenable[0]
                    && avsWritedata[CTRL_STOP];
  assign events = {evBusErr, evMismatch, evHashDone};
  assign secondary_branch_disable    = cfg_q[CFG_BRANCH_DIS];
  assign endMonDis = cfg_q[CFG_ENDMON_DIS];
  assign wbForce   = cfg_q[CFG_WRBACK_DIS] && !cfg_q[CFG_AUTO_CMP];

  // Register file and bus answer.
  always_comb begin
    cfg_d    = cfg_q;
    mask_d   = mask_q;
    rdata_d  = rdata_q;
    wait_d   = !((avsRead || avsWrite) && wait_q);
    status_d = status_q;
    if (wrAcc && avsAddress == OFF_CFG) begin
      cfg_d = wrMerged[CFG_W-1:0];
    end
    if (wrAcc && avsAddress == OFF_MASK) begin
      mask_d = wrMerged[MASK_W-1:0];
    end
    if (wrAcc && avsAddress == OFF_CLEAR) begin
      status_d = status_q & ~wrMerged[MASK_W-1:0];
    end
    // A new event wins over a clear in the same cycle.
    status_d = status_d | events;
    if (rdAcc) begin
      unique case (avsAddress)
        OFF_CFG:    rdata_d = 32'(cfg_q);
        OFF_MASK:   rdata_d = 32'(mask_q);
        OFF_STATUS: rdata_d = 32'(status_q);
        default:    rdata_d = 32'h0000_0000;
      endcase
    end
    irq_d = |(status_q & mask_q);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q    <= CFG_RST;
      mask_q   <= MASK_RST;
      status_q <= '0;
      rdata_q  <= '0;
      wait_q   <= 1'b1;
      irq_q    <= 1'b0;
    end else begin
      cfg_q    <= cfg_d;
      mask_q   <= mask_d;
      status_q <= status_d;
      rdata_q  <= rdata_d;
      wait_q   <= wait_d;
      irq_q    <= irq_d;
    end
  end

  // List sequencer.
  always_comb begin
    state_d    = state_q;
    refPass_d  = refPass_q;
    mon_d      = mon_q;
    restart_d  = 1'b0;
    wrap_d     = wrap_q;
    endMon_d   = endMon_q;
    last_d     = last_q;
    region_d   = region_q;
    next_d     = next_q;
    noWb_d     = noWb_q;
    timerStart = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (cmdStart) begin
          state_d   = ST_FETCH;
          restart_d = 1'b1;
          refPass_d = cfg_q[CFG_AUTO];
          mon_d     = 1'b0;
        end
      end
      ST_FETCH: begin
        if (descValid) begin
          state_d  = ST_XFER;
          region_d = descRegion;
          wrap_d   = descWrap;
          last_d   = descLast;
          next_d   = secondary_branch_disable ? 32'h0000_0000 : descNext;
          endMon_d = descEndMon && !endMonDis;
          noWb_d   = wbForce ? 1'b1 : descNoWb;
        end
      end
      ST_XFER: begin
        if (xferDone) begin
          if (endMon_q || (last_q && !wrap_q)) begin
            state_d = ST_IDLE;
            mon_d   = 1'b0;
          end else begin
            state_d    = ST_PAUSE;
            timerStart = 1'b1;
            if (last_q && refPass_q) begin
              refPass_d = 1'b0;
              mon_d     = 1'b1;
            end
          end
        end
      end
      ST_PAUSE: begin
        if (timerDone) begin
          state_d   = ST_FETCH;
          restart_d = last_q;
        end
      end
    endcase
    if (cmdStop) begin
      state_d = ST_IDLE;
      mon_d   = 1'b0;
    end
    fetch_d = state_d == ST_FETCH;
    xfer_d  = state_d == ST_XFER;
    busy_d  = state_d != ST_IDLE;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q   <= ST_IDLE;
      refPass_q <= 1'b0;
      mon_q     <= 1'b0;
      restart_q <= 1'b0;
      wrap_q    <= 1'b0;
      endMon_q  <= 1'b0;
      last_q    <= 1'b0;
      region_q  <= 2'h0;
      next_q    <= 32'h0000_0000;
      noWb_q    <= 1'b0;
      {fetch_q, xfer_q, busy_q} <= 3'h0;
    end else begin
      state_q   <= state_d;
      refPass_q <= refPass_d;
      mon_q     <= mon_d;
      restart_q <= restart_d;
      wrap_q    <= wrap_d;
      endMon_q  <= endMon_d;
      last_q    <= last_d;
      region_q  <= region_d;
      next_q    <= next_d;
      noWb_q    <= noWb_d;
      {fetch_q, xfer_q, busy_q} <= {fetch_d, xfer_d, busy_d};
    end
  end

  imlc_burden_timer u_timer (
    .clk      (clk),
    .rstn     (rstn),
    .start    (timerStart),
    .exponent (cfg_q[CFG_BURDEN_MSB:CFG_BURDEN_LSB]),
    .done     (timerDone)
  );

  assign avsReaddata    = rdata_q;
  assign avsWaitrequest = wait_q;
  assign fetchReq       = fetch_q;
  assign restartList    = restart_q;
  assign xferReq        = xfer_q;
  assign xferRegion     = region_q;
  assign xferNext       = next_q;
  assign xferNoWb       = noWb_q;
  assign busy           = busy_q;
  assign monitoring     = mon_q;
  assign irq            = irq_q;

  // Helper counter of cycles spent between transfers.
  logic [16:0] pauseCnt_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pauseCnt_q <= '0;
    end else begin
      pauseCnt_q <= (state_q == ST_PAUSE) ? pauseCnt_q + 17'h00001 : 17'h00000;
    end
  end

  sequence s_take;
    state_q == ST_FETCH && descValid;
  endsequence
  sequence s_refEnd;
    state_q == ST_XFER && xferDone && last_q && wrap_q && refPass_q && !endMon_q && !cmdStop;
  endsequence

  property p_auto;
    @(posedge clk) disable iff (!rstn) s_refEnd |=> mon_q && state_q == ST_PAUSE;
  endproperty
  a_auto: assert property (p_auto) else $error("monitoring not entered");

  property p_burden;
    @(posedge clk) disable iff (!rstn)
      state_q == ST_PAUSE && timerDone
      |-> pauseCnt_q == (17'h00001 << cfg_q[CFG_BURDEN_MSB:CFG_BURDEN_LSB]);
  endproperty
  a_burden: assert property (p_burden) else $error("burden gap wrong");

  property p_branch;
    @(posedge clk) disable iff (!rstn) s_take ##0 secondary_branch_disable |=> xferNext == 32'h0000_0000;
  endproperty
  a_branch: assert property (p_branch) else $error("next pointer not zero");

  property p_endMon;
    @(posedge clk) disable iff (!rstn) s_take ##0 endMonDis |=> !endMon_q;
  endproperty
  a_endMon: assert property (p_endMon) else $error("end flag not ignored");

  property p_wbOff;
    @(posedge clk) disable iff (!rstn)
      s_take ##0 (cfg_q[CFG_WRBACK_DIS] && !cfg_q[CFG_AUTO_CMP]) |=> xferNoWb;
  endproperty
  a_wbOff: assert property (p_wbOff) else $error("write-back not forced off");

  property p_autoCmp;
    @(posedge clk) disable iff (!rstn)
      s_take ##0 cfg_q[CFG_AUTO_CMP] |=> xferNoWb == $past(descNoWb);
  endproperty
  a_autoCmp: assert property (p_autoCmp) else $error("write-back disable not overridden");

  property p_busErr;
    @(posedge clk) disable iff (!rstn) (evBusErr & mask_q[11:8]) != 4'h0 |-> ##2 irq;
  endproperty
  a_busErr: assert property (p_busErr) else $error("bus error irq missing");

  property p_mism;
    @(posedge clk) disable iff (!rstn) (evMismatch & mask_q[7:4]) != 4'h0 |-> ##2 irq;
  endproperty
  a_mism: assert property (p_mism) else $error("mismatch irq missing");

  property p_hash;
    @(posedge clk) disable iff (!rstn) (evHashDone & mask_q[3:0]) != 4'h0 |-> ##2 irq;
  endproperty
  a_hash: assert property (p_hash) else $error("hash done irq missing");

  property p_quiet;
    @(posedge clk) disable iff (!rstn) (status_q & mask_q) == 12'h000 |=> !irq;
  endproperty
  a_quiet: assert property (p_quiet) else $error("irq without enabled flag");

  property p_rst;
    @(posedge clk) $rose(rstn) |-> cfg_q == CFG_RST && mask_q == MASK_RST;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule : imlc_top
`default_nettype wire

// File: pkg/imlc_pkg.sv
`default_nettype none
package imlc_pkg;
  // Register byte offsets on the Avalon-MM slave.
  localparam logic [4:0] OFF_CFG    = 5'h00;
  localparam logic [4:0] OFF_MASK   = 5'h04;
  localparam logic [4:0] OFF_STATUS = 5'h08;
  localparam logic [4:0] OFF_CLEAR  = 5'h0C;
  localparam logic [4:0] OFF_CTRL   = 5'h10;

  // Configuration register fields.
  localparam int CFG_W        = 10;
  localparam int CFG_WRBACK_DIS = 0;
  localparam int CFG_ENDMON_DIS = 1;
  localparam int CFG_BRANCH_DIS = 2;
  localparam int CFG_BURDEN_LSB = 4;
  localparam int CFG_BURDEN_MSB = 7;
  localparam int CFG_AUTO_CMP   = 8;
  localparam int CFG_AUTO     = 9;
  localparam logic [CFG_W-1:0] CFG_RST = 10'h000;

  // Mask, status and clear share one layout.
  localparam int MASK_W       = 12;
  localparam int MASK_HC_LSB  = 0;
  localparam int MASK_MM_LSB  = 4;
  localparam int MASK_BE_LSB  = 8;
  localparam logic [MASK_W-1:0] MASK_RST = 12'h000;

  // Control register command bits, self clearing.
  localparam int CTRL_START   = 0;
  localparam int CTRL_STOP    = 1;

  localparam int REGIONS      = 4;
  localparam int BURDEN_CNT_W = 16;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_XFER  = 4'b0100,
    ST_PAUSE = 4'b1000
  } imlc_state_e;
endpackage : imlc_pkg
`default_nettype wire

// File: design/imlc_burden_timer.sv
`timescale 1ns/1ps
`default_nettype none
module imlc_burden_timer
  import imlc_pkg::*;
(
  // Clock and reset.
  input  wire logic                    clk,
  input  wire logic                    rstn,
  // Control.
  input  wire logic                    start,
  input  wire logic [3:0]              exponent,
  output logic                         done
);
  logic [BURDEN_CNT_W-1:0] cnt_q, cnt_d;
  logic                    run_q, run_d;
  logic                    done_q, done_d;

  // The done pulse comes exactly two to the exponent plus one cycles after start.
  always_comb begin
    cnt_d  = cnt_q;
    run_d  = run_q;
    done_d = 1'b0;
    if (start) begin
      cnt_d = (BURDEN_CNT_W'(1) << exponent) - BURDEN_CNT_W'(1);
      run_d = 1'b1;
    end else if (run_q) begin
      if (cnt_q == '0) begin
        run_d  = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - BURDEN_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q  <= '0;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      run_q  <= run_d;
      done_q <= done_d;
    end
  end

  assign done = done_q;
endmodule : imlc_burden_timer
`default_nettype wire

// File: sim/imlc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module imlc_mem_model (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rstn,
  // Descriptor content and answer delay set by the bench.
  input  wire logic [5:0]  descIn,
  input  wire logic [31:0] nextIn,
  input  wire logic [3:0]  lat,
  // Walker and transfer side.
  input  wire logic        fetchReq,
  input  wire logic        xferReq,
  output logic             descValid,
  output logic [1:0]       descRegion,
  output logic             descWrap,
  output logic             descEndMon,
  output logic             descNoWb,
  output logic             descLast,
  output logic [31:0]      descNext,
  output logic             xferDone
);
  logic [3:0] cnt;

  // Outside a valid beat the fields show the inverse, so stale data never passes.
  assign {descRegion, descWrap, descEndMon, descNoWb, descLast} = descValid ? descIn : ~descIn;
  assign descNext = descValid ? nextIn : ~nextIn;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      descValid <= 1'b0;
      xferDone  <= 1'b0;
      cnt       <= 4'h0;
    end else begin
      descValid <= 1'b0;
      xferDone  <= 1'b0;
      if ((fetchReq && !descValid) || (xferReq && !xferDone)) begin
        cnt <= (cnt == lat) ? 4'h0 : cnt + 4'h1;
        if (cnt == lat) begin
          descValid <= fetchReq;
          xferDone  <= xferReq & ~fetchReq;
        end
      end else begin
        // A request cut short by a stop must not shorten the next answer.
        cnt <= 4'h0;
      end
    end
  end
endmodule : imlc_mem_model
`default_nettype wire

// File: sim/integrity_monitor_list_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module integrity_monitor_list_control_tb;
  import imlc_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [4:0]  avsAddress = 5'h00;
  logic        avsRead = 1'b0;
  logic        avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0, nextIn = 32'h0, avsReaddata, xferNext, descNext, rd;
  logic [3:0]  avsByteenable = 4'hF, lat = 4'h1;
  logic [11:0] ev = 12'h000;
  logic [5:0]  descIn = 6'h00;
  logic [1:0]  descRegion, xferRegion;
  logic        avsWaitrequest, fetchReq, restartList, descValid, descWrap, descEndMon;
  logic        descNoWb, descLast, xferReq, xferNoWb, xferDone, busy, monitoring, irq;
  logic [2:0]  watch;
  int          mismatches = 0;
  int          compares = 0;

  assign watch = {monitoring, xferReq, fetchReq};

  imlc_top dut (.clk, .rstn, .avsAddress, .avsRead, .avsWrite, .avsWritedata,
    .avsByteenable, .avsReaddata, .avsWaitrequest, .fetchReq, .restartList, .descValid,
    .descRegion, .descWrap, .descEndMon, .descNoWb, .descLast, .descNext, .xferReq,
    .xferRegion, .xferNext, .xferNoWb, .xferDone, .evHashDone(ev[3:0]),
    .evMismatch(ev[7:4]), .evBusErr(ev[11:8]), .busy, .monitoring, .irq);

  imlc_mem_model mem (.clk, .rstn, .descIn, .nextIn, .lat, .fetchReq, .xferReq,
    .descValid, .descRegion, .descWrap, .descEndMon, .descNoWb, .descLast, .descNext,
    .xferDone);

  initial begin
    forever #5 clk = ~clk;
  end

  task test_done;
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    avsAddress   <= a;
    avsWrite     <= wr;
    avsRead      <= ~wr;
    avsWritedata <= d;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (avsWaitrequest !== 1'b0 && i < 50);
    chk("waitrequest", 32'h0, 32'(avsWaitrequest));
    if (avsWaitrequest !== 1'b0) test_done();
    rd = avsReaddata;
    avsWrite <= 1'b0;
    avsRead  <= 1'b0;
  endtask : bus

  task automatic waitHi(input int k);
    int i;
    for (i = 0; i < 300 && watch[k] !== 1'b1; i++) @(posedge clk);
    chk("wait", 32'h1, 32'(watch[k]));
    if (watch[k] !== 1'b1) test_done();
  endtask : waitHi

  task pulse(input int b);
    @(posedge clk);
    ev <= 12'h001 << b;
    @(posedge clk);
    ev <= 12'h000;
    repeat (3) @(posedge clk);
  endtask : pulse

  task t_regs;
    bus(1'b0, OFF_CFG, 32'h0);
    chk("cfg reset", 32'h0, rd);
    bus(1'b0, OFF_MASK, 32'h0);
    chk("mask reset", 32'h0, rd);
    bus(1'b1, OFF_CFG, 32'h3F7);
    bus(1'b0, OFF_CFG, 32'h0);
    chk("cfg readback", 32'h3F7, rd);
    bus(1'b0, 5'h14, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, OFF_CFG, 32'h0);
  endtask : t_regs

  task t_irq;
    int f;
    for (f = 0; f < 3; f++) begin
      bus(1'b1, OFF_MASK, 32'h1 << (f * 5));
      pulse(f * 4 + 3);
      chk("masked irq", 32'h0, 32'(irq));
      bus(1'b0, OFF_STATUS, 32'h0);
      chk("status", 32'h8 << (f * 4), rd);
      pulse(f * 5);
      chk("irq", 32'h1, 32'(irq));
      bus(1'b1, OFF_CLEAR, 32'hFFF);
      repeat (3) @(posedge clk);
      chk("irq cleared", 32'h0, 32'(irq));
    end
  endtask : t_irq

  task t_walk(input logic [31:0] cfg);
    int n;
    logic [31:0] gap;
    descIn <= {2'h2, 1'b0, 1'b1, 1'b0, 1'b0};
    nextIn <= 32'h0000_1234;
    gap = (32'h1 << cfg[CFG_BURDEN_MSB:CFG_BURDEN_LSB]) + 32'h1;
    bus(1'b1, OFF_CFG, cfg);
    bus(1'b1, OFF_CTRL, 32'h1);
    @(posedge clk);
    chk("restart", 32'h1, 32'(restartList));
    waitHi(1);
    chk("next", 32'h0, xferNext);
    chk("nowb", 32'h1, 32'(xferNoWb));
    chk("region", 32'h2, 32'(xferRegion));
    for (n = 0; n < 300 && xferReq === 1'b1; n++) @(posedge clk);
    chk("xfer end", 32'h0, 32'(xferReq));
    if (xferReq !== 1'b0) test_done();
    for (n = 0; n < 30 && fetchReq !== 1'b1 && busy === 1'b1; n++) @(posedge clk);
    if (cfg[CFG_ENDMON_DIS]) chk("pause", gap, 32'(n));
    else chk("eom idle", 32'h0, 32'(busy));
    bus(1'b1, OFF_CTRL, 32'h2);
    repeat (2) @(posedge clk);
    chk("stopped", 32'h0, 32'(busy));
  endtask : t_walk

  task t_auto;
    descIn <= {2'h1, 1'b1, 1'b0, 1'b0, 1'b1};
    bus(1'b1, OFF_CFG, 32'h301);
    bus(1'b1, OFF_CTRL, 32'h1);
    waitHi(1);
    chk("reference pass", 32'h0, 32'(monitoring));
    chk("auto compare nowb", 32'h0, 32'(xferNoWb));
    waitHi(2);
    repeat (2) @(posedge clk);
    chk("wrap restart", 32'h1, 32'(restartList));
    bus(1'b1, OFF_CTRL, 32'h2);
  endtask : t_auto

  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_irq();
    t_walk(32'h37);
    t_walk(32'h35);
    t_auto();
    test_done();
  end
endmodule : integrity_monitor_list_control_tb
`default_nettype wire
